// ---- common/t16wm_regs.vh ----
// Purpose: register map, fields and constants of the 16-bit timer block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: offsets 0x2f and 0x2e are indices; byte address is four times
`ifndef T16WM_REGS_VH
`define T16WM_REGS_VH
// register indices
`define T16WM_IDX_CTRL_A 8'h2f
`define T16WM_IDX_CTRL_B 8'h2e
`define T16WM_IDX_CMP_A 8'h30
`define T16WM_IDX_CMP_B 8'h31
`define T16WM_IDX_CAPT 8'h32
`define T16WM_IDX_COUNT 8'h33
`define T16WM_IDX_STATUS 8'h34
`define T16WM_IDX_DIR 8'h35
// reset values
`define T16WM_CTRL_A_RST 8'h00
`define T16WM_CTRL_B_RST 8'h00
// control a fields
`define T16WM_A_COMA_HI 7
`define T16WM_A_COMA_LO 6
`define T16WM_A_COMB_HI 5
`define T16WM_A_COMB_LO 4
`define T16WM_A_WGM_HI 1
`define T16WM_A_WGM_LO 0
`define T16WM_A_WMASK 8'hf3
// control b fields
`define T16WM_B_NOISE 7
`define T16WM_B_EDGE 6
`define T16WM_B_WGM_HI 4
`define T16WM_B_WGM_LO 3
`define T16WM_B_CS_HI 2
`define T16WM_B_CS_LO 0
`define T16WM_B_WMASK 8'hdf
// status fields
`define T16WM_ST_OVF 0
`define T16WM_ST_UP 1
`define T16WM_ST_CAPT_OFF 2
// tops
`define T16WM_TOP_MAX 16'hffff
`define T16WM_TOP_8 16'h00ff
`define T16WM_TOP_9 16'h01ff
`define T16WM_TOP_10 16'h03ff
`define T16WM_BOTTOM 16'h0000
// output mode codes
`define T16WM_COM_OFF 2'h0
`define T16WM_COM_TGL 2'h1
`define T16WM_COM_CLR 2'h2
`define T16WM_COM_SET 2'h3
// clock select codes
`define T16WM_CS_STOP 3'h0
`define T16WM_CS_DIV1 3'h1
`define T16WM_CS_DIV8 3'h2
`define T16WM_CS_DIV64 3'h3
`define T16WM_CS_DIV256 3'h4
`define T16WM_CS_DIV1024 3'h5
`define T16WM_CS_EXT_FALL 3'h6
`define T16WM_CS_EXT_RISE 3'h7
// prescaler taps
`define T16WM_PS_W 10
`define T16WM_PS_M8 10'h007
`define T16WM_PS_M64 10'h03f
`define T16WM_PS_M256 10'h0ff
`define T16WM_PS_M1024 10'h3ff
`endif

// ---- logic/t16wm_prescale.v ----
// Purpose: count-enable source for the timer
// Assumes: external count pin already synchronised
// Notes: one-cycle enable pulses, no second clock
`timescale 1ns/1ps
`include "t16wm_regs.vh"
module t16wm_prescale (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire [2:0] clock_select,
  input wire ext_sync,
  // enable out
  output reg tick
);
  reg [`T16WM_PS_W-1:0] div_reg;
  reg ext_prev_reg;
  wire fall;
  wire rise;
  assign fall = ext_prev_reg & ~ext_sync;
  assign rise = ~ext_prev_reg & ext_sync;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= {`T16WM_PS_W{1'b0}};
      ext_prev_reg <= 1'b0;
      tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 1'b1;
      ext_prev_reg <= ext_sync;
      case (clock_select)
        `T16WM_CS_STOP: tick <= 1'b0;
        `T16WM_CS_DIV1: tick <= 1'b1;
        `T16WM_CS_DIV8: tick <= (div_reg & `T16WM_PS_M8) == `T16WM_PS_M8;
        `T16WM_CS_DIV64: tick <= (div_reg & `T16WM_PS_M64) == `T16WM_PS_M64;
        `T16WM_CS_DIV256: tick <= (div_reg & `T16WM_PS_M256) ==
          `T16WM_PS_M256;
        `T16WM_CS_DIV1024: tick <= div_reg == `T16WM_PS_M1024;
        `T16WM_CS_EXT_FALL: tick <= fall;
        default: tick <= rise;
      endcase
    end
  end
endmodule // t16wm_prescale

// ---- logic/t16wm_outpin.v ----
// Purpose: compare output waveform and pin mux for one channel
// Assumes: match and direction qualifiers arrive on pclk
// Notes: pin value comes straight from flip-flops
`timescale 1ns/1ps
`include "t16wm_regs.vh"
module t16wm_outpin (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // events
  input wire tick,
  input wire match,
  input wire at_bottom,
  input wire counting_up,
  input wire [1:0] mode_class,
  input wire allow_toggle,
  input wire ignore_match,
  // control
  input wire [1:0] output_mode,
  input wire port_dir,
  input wire port_value,
  // pin
  output reg pin_out,
  output reg pin_oe,
  output reg wave
);
  // mode_class: 0 non-pwm, 1 fast pwm, 2 dual slope pwm
  reg wave_next;
  wire connected;
  assign connected = output_mode != `T16WM_COM_OFF;
  always @* begin
    wave_next = wave;
    if (tick) begin
      case (mode_class)
        2'h0: begin
          if (match) begin
            case (output_mode)
              `T16WM_COM_TGL: wave_next = ~wave;
              `T16WM_COM_CLR: wave_next = 1'b0;
              `T16WM_COM_SET: wave_next = 1'b1;
              default: wave_next = wave;
            endcase
          end
        end
        2'h1: begin
          if (output_mode == `T16WM_COM_TGL) begin
            if (match && allow_toggle)
              wave_next = ~wave;
          end else if (output_mode[1]) begin
            if (at_bottom)
              wave_next = ~output_mode[0];
            else if (match && !ignore_match)
              wave_next = output_mode[0];
          end
        end
        default: begin
          if (output_mode == `T16WM_COM_TGL) begin
            if (match && allow_toggle)
              wave_next = ~wave;
          end else if (output_mode[1] && match) begin
            wave_next = counting_up ? output_mode[0] :
              ~output_mode[0];
          end
        end
      endcase
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      wave <= wave_next;
      pin_out <= connected && allow_toggle_or_pwm(output_mode, mode_class,
        allow_toggle) ? wave_next : port_value;
      pin_oe <= port_dir;
    end
  end
  // code 01 in pwm modes keeps the port unless toggling is allowed
  function allow_toggle_or_pwm;
    input [1:0] om;
    input [1:0] mc;
    input at;
    begin
      allow_toggle_or_pwm = !(mc != 2'h0 && om == `T16WM_COM_TGL && !at);
    end
  endfunction
endmodule // t16wm_outpin

// ---- logic/t16wm_timer.v ----
// Purpose: 16-bit timer with waveform modes and two compare outputs
// Assumes: APB slave, 32-bit data, registers at four times their index
// Notes: capture pin and count pin pass two flip-flops first
// Behaviour
// - nonzero output mode routes channel waveform to pin over port value
// - pin driver enabled only when the port direction bit is set
// - non-pwm: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm code 10: clear on match, set at bottom
// - fast pwm code 11: set on match, clear at bottom
// - pwm code 01: off if mode bit 3 zero, else toggle a only
// - fast pwm: match at top ignored when code upper bit set
// - dual slope code 10: clear on up match, set on down match
// - dual slope code 11: set on up match, clear on down match
// - 4-bit waveform mode split over control a and control b
// - mode 0 free runs to 0xffff, immediate load, overflow at max
// - modes 4, 12 clear on match a or capture, overflow at max
// - phase correct modes load at top, overflow at bottom
// - fast pwm modes load at top, overflow at top
// - modes 8, 9 load at bottom and overflow at bottom
// - clock select: stop, divide by 1..1024, or external edges
// - capture used as top disables the capture input
`timescale 1ns/1ps
`include "t16wm_regs.vh"
module t16wm_timer (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pins
  input wire capture_pin,
  input wire external_count_pin,
  input wire [1:0] port_value,
  output reg compare_out_a,
  output reg compare_out_a_oe,
  output reg compare_out_b,
  output reg compare_out_b_oe,
  output reg overflow_flag
);
  reg [7:0] timer_control_a_reg;
  reg [7:0] timer_control_b_reg;
  reg [15:0] cmp_buf_a_reg;
  reg [15:0] cmp_buf_b_reg;
  reg [15:0] compare_value_a_reg;
  reg [15:0] compare_value_b_reg;
  reg [15:0] capture_value_reg;
  reg [15:0] counter_value_reg;
  reg [1:0] port_dir_reg;
  reg up_reg;
  reg ovf_reg;
  reg [1:0] cap_sync_reg;
  reg [1:0] ext_sync_reg;
  reg cap_prev_reg;
  reg [3:0] cap_filt_reg;
  reg cap_clean_reg;
  reg [15:0] counter_next;
  reg up_next;
  reg [15:0] top;
  reg [1:0] mclass;
  reg load_now;
  reg ovf_set;
  wire tick;
  wire [3:0] waveform_mode;
  wire [1:0] channel_a_output_mode;
  wire [1:0] channel_b_output_mode;
  wire [2:0] clock_select;
  wire cap_as_top;
  wire at_top;
  wire at_bottom;
  wire match_a;
  wire match_b;
  wire pin_a;
  wire pin_b;
  wire oe_a;
  wire oe_b;
  wire access;
  wire wr;
  wire [7:0] idx;
  wire addr_ok;
  wire cap_edge;
  wire cap_in;

  assign waveform_mode = {timer_control_b_reg[`T16WM_B_WGM_HI:`T16WM_B_WGM_LO],
    timer_control_a_reg[`T16WM_A_WGM_HI:`T16WM_A_WGM_LO]};
  assign channel_a_output_mode =
    timer_control_a_reg[`T16WM_A_COMA_HI:`T16WM_A_COMA_LO];
  assign channel_b_output_mode =
    timer_control_a_reg[`T16WM_A_COMB_HI:`T16WM_A_COMB_LO];
  assign clock_select = timer_control_b_reg[`T16WM_B_CS_HI:`T16WM_B_CS_LO];
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign idx = paddr[9:2];
  assign addr_ok = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 &&
    (idx == `T16WM_IDX_CTRL_A || idx == `T16WM_IDX_CTRL_B ||
    idx == `T16WM_IDX_CMP_A || idx == `T16WM_IDX_CMP_B ||
    idx == `T16WM_IDX_CAPT || idx == `T16WM_IDX_COUNT ||
    idx == `T16WM_IDX_STATUS || idx == `T16WM_IDX_DIR);

  // capture uses the pin only when it is not the top source
  assign cap_as_top = waveform_mode == 4'h8 || waveform_mode == 4'ha ||
    waveform_mode == 4'hc || waveform_mode == 4'he;
  assign cap_in = timer_control_b_reg[`T16WM_B_NOISE] ? cap_clean_reg :
    cap_sync_reg[1];
  assign cap_edge = !cap_as_top && (cap_in != cap_prev_reg) &&
    (cap_in == timer_control_b_reg[`T16WM_B_EDGE]);
  // top source and mode class per waveform mode
  always @* begin
    top = `T16WM_TOP_MAX;
    mclass = 2'h0;
    load_now = 1'b1;
    case (waveform_mode)
      4'h0: top = `T16WM_TOP_MAX;
      4'h1, 4'h2, 4'h3: begin
        top = topfix(waveform_mode[1:0]);
        mclass = 2'h2;
        load_now = 1'b0;
      end
      4'h4: top = compare_value_a_reg;
      4'h5, 4'h6, 4'h7: begin
        top = topfix(waveform_mode[1:0]);
        mclass = 2'h1;
        load_now = 1'b0;
      end
      4'h8, 4'ha: begin
        top = capture_value_reg;
        mclass = 2'h2;
        load_now = 1'b0;
      end
      4'h9, 4'hb: begin
        top = compare_value_a_reg;
        mclass = 2'h2;
        load_now = 1'b0;
      end
      4'hc: top = capture_value_reg;
      4'he: begin
        top = capture_value_reg;
        mclass = 2'h1;
        load_now = 1'b0;
      end
      4'hf: begin
        top = compare_value_a_reg;
        mclass = 2'h1;
        load_now = 1'b0;
      end
      default: top = `T16WM_TOP_MAX; // reserved mode 13 runs as normal
    endcase
  end

  assign at_top = counter_value_reg == top;
  assign at_bottom = counter_value_reg == `T16WM_BOTTOM;
  assign match_a = counter_value_reg == compare_value_a_reg;
  assign match_b = counter_value_reg == compare_value_b_reg;

  // count sequence and overflow event
  always @* begin
    counter_next = counter_value_reg;
    up_next = up_reg;
    ovf_set = 1'b0;
    if (tick) begin
      if (mclass == 2'h2) begin
        if (up_reg && at_top) begin
          up_next = 1'b0;
          counter_next = counter_value_reg - 16'h0001;
        end else if (!up_reg && at_bottom) begin
          up_next = 1'b1;
          counter_next = counter_value_reg + 16'h0001;
          ovf_set = 1'b1;
        end else begin
          counter_next = up_reg ? counter_value_reg + 16'h0001 :
            counter_value_reg - 16'h0001;
        end
      end else begin
        up_next = 1'b1;
        counter_next = at_top ? `T16WM_BOTTOM :
          counter_value_reg + 16'h0001;
        if (mclass == 2'h1)
          ovf_set = at_top;
        else
          ovf_set = counter_value_reg == `T16WM_TOP_MAX;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_a_reg <= `T16WM_CTRL_A_RST;
      timer_control_b_reg <= `T16WM_CTRL_B_RST;
      cmp_buf_a_reg <= 16'h0000;
      cmp_buf_b_reg <= 16'h0000;
      compare_value_a_reg <= 16'h0000;
      compare_value_b_reg <= 16'h0000;
      capture_value_reg <= 16'h0000;
      counter_value_reg <= 16'h0000;
      port_dir_reg <= 2'h0;
      up_reg <= 1'b1;
      ovf_reg <= 1'b0;
      cap_sync_reg <= 2'h0;
      ext_sync_reg <= 2'h0;
      cap_prev_reg <= 1'b0;
      cap_filt_reg <= 4'h0;
      cap_clean_reg <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      cap_sync_reg <= {cap_sync_reg[0], capture_pin};
      ext_sync_reg <= {ext_sync_reg[0], external_count_pin};
      cap_filt_reg <= {cap_filt_reg[2:0], cap_sync_reg[1]};
      if (cap_filt_reg == 4'hf)
        cap_clean_reg <= 1'b1;
      else if (cap_filt_reg == 4'h0)
        cap_clean_reg <= 1'b0;
      cap_prev_reg <= cap_in;
      counter_value_reg <= counter_next;
      up_reg <= up_next;
      if (cap_edge)
        capture_value_reg <= counter_value_reg;
      // buffered compare copy at the mode's update point
      if (tick && ((mclass == 2'h2 && waveform_mode[3:1] != 3'h5 &&
          waveform_mode[3] && !up_reg && at_bottom) ||
          (mclass == 2'h1 && at_top) ||
          (mclass == 2'h2 && !(waveform_mode[3] &&
          waveform_mode[3:1] != 3'h5) && up_reg && at_top))) begin
        compare_value_a_reg <= cmp_buf_a_reg;
        compare_value_b_reg <= cmp_buf_b_reg;
      end
      pready <= access && !pready;
      pslverr <= access && !pready && !addr_ok;
      if (access && !pready && !pwrite) begin
        case (idx)
          `T16WM_IDX_CTRL_A: prdata <= {24'h0, timer_control_a_reg};
          `T16WM_IDX_CTRL_B: prdata <= {24'h0, timer_control_b_reg};
          `T16WM_IDX_CMP_A: prdata <= {16'h0, cmp_buf_a_reg};
          `T16WM_IDX_CMP_B: prdata <= {16'h0, cmp_buf_b_reg};
          `T16WM_IDX_CAPT: prdata <= {16'h0, capture_value_reg};
          `T16WM_IDX_COUNT: prdata <= {16'h0, counter_value_reg};
          `T16WM_IDX_STATUS: prdata <= {29'h0, cap_as_top, up_reg, ovf_reg};
          `T16WM_IDX_DIR: prdata <= {30'h0, port_dir_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (wr && pready) begin
        case (idx)
          `T16WM_IDX_CTRL_A:
            timer_control_a_reg <= pwdata[7:0] & `T16WM_A_WMASK;
          `T16WM_IDX_CTRL_B:
            timer_control_b_reg <= pwdata[7:0] & `T16WM_B_WMASK;
          `T16WM_IDX_CMP_A: begin
            cmp_buf_a_reg <= pwdata[15:0];
            if (load_now)
              compare_value_a_reg <= pwdata[15:0];
          end
          `T16WM_IDX_CMP_B: begin
            cmp_buf_b_reg <= pwdata[15:0];
            if (load_now)
              compare_value_b_reg <= pwdata[15:0];
          end
          `T16WM_IDX_CAPT:
            if (cap_as_top)
              capture_value_reg <= pwdata[15:0];
          `T16WM_IDX_COUNT: counter_value_reg <= pwdata[15:0];
          `T16WM_IDX_DIR: port_dir_reg <= pwdata[1:0];
          default: ;
        endcase
      end
      // write one clears, a new event wins
      if (ovf_set)
        ovf_reg <= 1'b1;
      else if (wr && pready && idx == `T16WM_IDX_STATUS &&
          pwdata[`T16WM_ST_OVF])
        ovf_reg <= 1'b0;
      overflow_flag <= ovf_set || ovf_reg;
      compare_out_a <= pin_a;
      compare_out_a_oe <= oe_a;
      compare_out_b <= pin_b;
      compare_out_b_oe <= oe_b;
    end
  end

  function [15:0] topfix;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: topfix = `T16WM_TOP_8;
        2'h2: topfix = `T16WM_TOP_9;
        default: topfix = `T16WM_TOP_10;
      endcase
    end
  endfunction
  t16wm_prescale u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .clock_select(clock_select),
    .ext_sync(ext_sync_reg[1]),
    .tick(tick)
  );
  t16wm_outpin u_out_a (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .match(match_a),
    .at_bottom(at_bottom),
    .counting_up(up_reg),
    .mode_class(mclass),
    .allow_toggle(waveform_mode[3]),
    .ignore_match(match_a && at_top),
    .output_mode(channel_a_output_mode),
    .port_dir(port_dir_reg[0]),
    .port_value(port_value[0]),
    .pin_out(pin_a),
    .pin_oe(oe_a),
    .wave()
  );
  t16wm_outpin u_out_b (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .match(match_b),
    .at_bottom(at_bottom),
    .counting_up(up_reg),
    .mode_class(mclass),
    .allow_toggle(1'b0),
    .ignore_match(match_b && at_top),
    .output_mode(channel_b_output_mode),
    .port_dir(port_dir_reg[1]),
    .port_value(port_value[1]),
    .pin_out(pin_b),
    .pin_oe(oe_b),
    .wave()
  );
endmodule // t16wm_timer

// ---- dv/t16wm_props.sv ----
// Purpose: port-level checks for the 16-bit timer block
// Assumes: apb master holds each request until pready
// Notes: shadows of control fields follow accepted writes
`timescale 1ns/1ps
module t16wm_props (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins
  input wire capture_pin,
  input wire external_count_pin,
  input wire [1:0] port_value,
  input wire compare_out_a,
  input wire compare_out_a_oe,
  input wire compare_out_b,
  input wire compare_out_b_oe,
  input wire overflow_flag
);
  wire wr_ok = psel && penable && pready && pwrite;
  wire st_clr = wr_ok && paddr == 12'h0d0 && pwdata[0];
  reg [1:0] com_a_reg;
  reg [1:0] dir_reg;
  reg [2:0] cs_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_a_reg <= 2'h0;
      dir_reg <= 2'h0;
      cs_reg <= 3'h0;
    end else if (wr_ok) begin
      if (paddr == 12'h0bc) com_a_reg <= pwdata[7:6];
      if (paddr == 12'h0b8) cs_reg <= pwdata[2:0];
      if (paddr == 12'h0d4) dir_reg <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_dir_quiet; $stable(dir_reg) [*4]; endsequence
  property p_ready_wait; s_access |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_in_access; pready |-> psel && penable; endproperty
  property p_err_unaligned;
    s_access ##0 (paddr[1:0] != 2'h0) |=> pslverr && pready;
  endproperty
  property p_oe_a; s_dir_quiet |-> compare_out_a_oe == dir_reg[0]; endproperty
  property p_oe_b; s_dir_quiet |-> compare_out_b_oe == dir_reg[1]; endproperty
  property p_port_a;
    (com_a_reg == 2'h0 && $stable(port_value)) [*6]
      |-> compare_out_a == port_value[0];
  endproperty
  property p_ovf_clear;
    $fell(overflow_flag) |-> $past(st_clr, 1) || $past(st_clr, 2);
  endproperty
  property p_stop_pin;
    (cs_reg == 3'h0 && $stable(com_a_reg) && $stable(port_value)) [*6]
      |-> $stable(compare_out_a);
  endproperty
  property p_stop_ovf; (cs_reg == 3'h0) [*6] |-> !$rose(overflow_flag); endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no pready");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  a_ready_in_access: assert property (p_ready_in_access) else $error("stray pready");
  a_err_unaligned: assert property (p_err_unaligned) else $error("no pslverr");
  a_oe_a: assert property (p_oe_a) else $error("oe a wrong");
  a_oe_b: assert property (p_oe_b) else $error("oe b wrong");
  a_port_a: assert property (p_port_a) else $error("port a lost");
  a_ovf_clear: assert property (p_ovf_clear) else $error("ovf lost");
  a_stop_pin: assert property (p_stop_pin) else $error("pin moved");
  a_stop_ovf: assert property (p_stop_ovf) else $error("ovf set");
endmodule // t16wm_props
bind t16wm_timer t16wm_props u_t16wm_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
  .external_count_pin(external_count_pin), .port_value(port_value),
  .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
  .compare_out_b(compare_out_b), .compare_out_b_oe(compare_out_b_oe),
  .overflow_flag(overflow_flag));

// ---- dv/t16wm_load.sv ----
// Purpose: loads on the two compare output pins
// Assumes: weak pull-down on each pin
// Notes: an undriven pin reads low
`timescale 1ns/1ps
module t16wm_load (
  // pins from the timer
  input wire pin_a,
  input wire oe_a,
  input wire pin_b,
  input wire oe_b,
  // levels seen at the load
  output wire line_a,
  output wire line_b
);
  assign line_a = oe_a ? pin_a : 1'b0;
  assign line_b = oe_b ? pin_b : 1'b0;
endmodule // t16wm_load

// ---- dv/tb.sv ----
// Purpose: register and waveform tests of the 16-bit timer
// Assumes: apb master with one request at a time
// Notes: pins measured through the load model
`timescale 1ns/1ps
`include "t16wm_regs.vh"
module tb;
  reg pclk, presetn, psel, penable, pwrite, capture_pin, external_count_pin;
  reg [11:0] paddr;
  reg [31:0] pwdata, q;
  reg [1:0] port_value;
  reg e, last;
  wire [31:0] prdata;
  wire pready, pslverr, oa, oa_oe, ob, ob_oe, ovf, line_a, line_b;
  integer err_count, tests_run, hi_a, hi_b, tg_a;
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; capture_pin = 0; external_count_pin = 0; port_value = 0;
    err_count = 0; tests_run = 0;
  end
  always #5 pclk = ~pclk;
  t16wm_timer u_t16wm_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .external_count_pin(external_count_pin),
    .port_value(port_value), .compare_out_a(oa), .compare_out_a_oe(oa_oe),
    .compare_out_b(ob), .compare_out_b_oe(ob_oe), .overflow_flag(ovf));
  t16wm_load u_t16wm_load (.pin_a(oa), .oe_a(oa_oe), .pin_b(ob),
    .oe_b(ob_oe), .line_a(line_a), .line_b(line_b));
  function [11:0] adr(input [7:0] idx);
    adr = {2'h0, idx, 2'h0};
  endfunction
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
        @(posedge pclk);
        n = n + 1;
      end
      q = prdata;
      e = pslverr;
      if (n >= 50) err_count = err_count + 1;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== ex) begin
        err_count = err_count + 1;
        $display("BAD %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task setup(input [3:0] m, input [1:0] ca, input [1:0] cb,
             input [15:0] va, input [15:0] vb, input [2:0] cs);
    begin
      apb(1, adr(`T16WM_IDX_CTRL_B), 32'h0);
      apb(1, adr(`T16WM_IDX_CMP_A), {16'h0, va});
      apb(1, adr(`T16WM_IDX_CMP_B), {16'h0, vb});
      apb(1, adr(`T16WM_IDX_CTRL_A), {24'h0, ca, cb, 2'h0, m[1:0]});
      apb(1, adr(`T16WM_IDX_COUNT), 32'h0);
      apb(1, adr(`T16WM_IDX_CTRL_B), {27'h0, m[3:2], cs});
      repeat (300) @(posedge pclk);
    end
  endtask
  task meas(input integer n);
    begin
      hi_a = 0; hi_b = 0; tg_a = 0;
      @(negedge pclk);
      last = line_a;
      repeat (n) begin
        @(negedge pclk);
        hi_a = hi_a + line_a;
        hi_b = hi_b + line_b;
        if (line_a !== last) tg_a = tg_a + 1;
        last = line_a;
      end
    end
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    close_out;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, adr(`T16WM_IDX_CTRL_A), 0); chk("ctrl_a rst", 0, q);
    apb(0, adr(`T16WM_IDX_CTRL_B), 0); chk("ctrl_b rst", 0, q);
    apb(1, adr(`T16WM_IDX_CTRL_A), 32'hff);
    apb(0, adr(`T16WM_IDX_CTRL_A), 0); chk("ctrl_a mask", 32'hf3, q);
    apb(1, adr(`T16WM_IDX_CTRL_A), 32'h0);
    apb(0, 12'h0fc, 0); chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    apb(0, 12'h0bd, 0); chk("unaligned err", 1, e);
    $display("test regs done");
    port_value <= 2'b10;
    apb(1, adr(`T16WM_IDX_DIR), 32'h0);
    repeat (8) @(posedge pclk);
    chk("pins off", 0, {oa_oe, ob_oe, line_a, line_b});
    apb(1, adr(`T16WM_IDX_DIR), 32'h3);
    repeat (8) @(posedge pclk);
    chk("port level", 4'hd, {oa_oe, ob_oe, line_a, line_b});
    setup(4, 2'h1, 2'h3, 2, 1, 1); meas(30);
    chk("ctc toggle", 10, tg_a);
    chk("ctc set", 30, hi_b);
    setup(4, 2'h2, 2'h0, 2, 1, 1); meas(30);
    chk("ctc clear", 0, hi_a);
    chk("ctc off", 30, hi_b);
    setup(0, 2'h0, 2'h0, 0, 0, 1);
    apb(1, adr(`T16WM_IDX_COUNT), 32'hfff0);
    repeat (30) @(posedge pclk);
    chk("ovf max", 1, ovf);
    apb(1, adr(`T16WM_IDX_STATUS), 32'h1);
    repeat (3) @(posedge pclk);
    chk("ovf clear", 0, ovf);
    setup(0, 2'h0, 2'h0, 0, 0, 0);
    apb(0, adr(`T16WM_IDX_COUNT), 0); chk("stopped", 0, q);
    apb(1, adr(`T16WM_IDX_CTRL_B), 32'h7);
    repeat (4) begin
      external_count_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      external_count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    apb(0, adr(`T16WM_IDX_COUNT), 0); chk("ext edges", 4, q);
    apb(1, adr(`T16WM_IDX_COUNT), 32'h0);
    apb(1, adr(`T16WM_IDX_CTRL_B), 32'h2);
    repeat (160) @(posedge pclk);
    apb(1, adr(`T16WM_IDX_CTRL_B), 32'h40);
    apb(0, adr(`T16WM_IDX_COUNT), 0);
    chk("div8", 1, q >= 20 && q <= 21);
    apb(1, adr(`T16WM_IDX_COUNT), 32'h1234);
    capture_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(0, adr(`T16WM_IDX_CAPT), 0); chk("capture", 32'h1234, q);
    capture_pin <= 1'b0;
    $display("test ctc normal done");
    setup(5, 2'h2, 2'h3, 16'h80, 16'h80, 1); meas(256);
    chk("fast sum", 256, hi_a + hi_b);
    chk("fast duty", 1, hi_a == 128 || hi_a == 129);
    chk("fast ovf", 1, ovf);
    apb(1, adr(`T16WM_IDX_STATUS), 32'h1);
    setup(1, 2'h2, 2'h3, 16'h80, 16'h80, 1);
    repeat (600) @(posedge pclk);
    meas(510);
    chk("dual sum", 510, hi_a + hi_b);
    chk("dual duty", 1, hi_a >= 254 && hi_a <= 258);
    setup(15, 2'h1, 2'h1, 9, 9, 1); meas(100);
    chk("pwm toggle a", 10, tg_a);
    chk("pwm b kept", 100, hi_b);
    setup(5, 2'h1, 2'h1, 16'h80, 16'h80, 1); meas(50);
    chk("pwm a off", 0, hi_a);
    chk("pwm b off", 50, hi_b);
    setup(15, 2'h2, 2'h3, 9, 9, 1); meas(100);
    chk("top match a", 100, hi_a);
    chk("top match b", 0, hi_b);
    setup(14, 2'h2, 2'h0, 4, 0, 1);
    apb(1, adr(`T16WM_IDX_CAPT), 32'h9);
    apb(1, adr(`T16WM_IDX_COUNT), 32'h0);
    capture_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    capture_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(0, adr(`T16WM_IDX_CAPT), 0); chk("capt top", 9, q);
    apb(0, adr(`T16WM_IDX_STATUS), 0);
    chk("capt off", 7, q);
    meas(100); chk("capt top duty", 40, hi_a);
    $display("test pwm done");
    close_out;
  end
endmodule // tb
